// file: shared/ssu_cfg.svh
// Address map, field positions and reset values of the serial unit register bank
`ifndef SSU_CFG_SVH
`define SSU_CFG_SVH
`define SSU_A_CMR      32'hF0010004
`define SSU_A_RCMR     32'hF0010010
`define SSU_A_RFMR     32'hF0010014
`define SSU_A_TCMR     32'hF0010018
`define SSU_A_TFMR     32'hF001001C
`define SSU_A_RC0R     32'hF0010038
`define SSU_A_RC1R     32'hF001003C
`define SSU_A_STAT     32'hF0010040
`define SSU_A_IER      32'hF0010044
`define SSU_A_IDR      32'hF0010048
`define SSU_A_IMR      32'hF001004C
`define SSU_A_WPMR     32'hF00100E4
`define SSU_A_WPSR     32'hF00100E8
`define SSU_SRC_VALID  12'hF33
`define SSU_STICKY     12'hF20
`define SSU_LOCK_KEY   24'h535343
`define SSU_KEY_HI     31
`define SSU_KEY_LO     8
`define SSU_VSRC_HI    23
`define SSU_VSRC_LO    8
`define SSU_EN_BIT     0
`define SSU_NO_SLOT    3'h7
`define SSU_CFG_RST    32'h00000000
`define SSU_MASK_RST   12'h000
`define SSU_VSRC_RST   16'h0000
`endif

// file: shared/ssu_pkg.sv
// Types shared by the serial unit register bank
package ssu_pkg;
  typedef logic [11:0] ssu_src_type;
  typedef logic [6:0][31:0] ssu_cfg_type;
  typedef enum logic [1:0] {
    SSU_IDLE = 2'h0,
    SSU_ACC  = 2'h1
  } ssu_bus_type;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ssu_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ssu_apb_rsp_type;
  typedef struct packed {
    ssu_bus_type     bus;
    ssu_apb_rsp_type rsp;
    logic            irq;
    ssu_src_type     mask;
    logic            lock_en;
    logic            viol;
    logic [15:0]     vsrc;
    ssu_cfg_type     cfg;
  } ssu_state_type;
  typedef struct packed {
    ssu_src_type flags;
  } ssu_flag_state_type;
endpackage

// file: verilog/ssu_flags.sv
// Sticky event flags with clear by returned bits
`include "ssu_cfg.svh"
module ssu_flags
  import ssu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire ssu_src_type set_in,
  input  wire ssu_src_type clr_in,
  output ssu_src_type      flags
);
  ssu_flag_state_type q;
  ssu_flag_state_type d;

  always_comb begin
    d = q;
    for (int i = 0; i < $bits(ssu_src_type); i++) begin
      // Set beats clear so an event in the clearing cycle is kept
      d.flags[i] = (q.flags[i] & ~clr_in[i]) | set_in[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign flags = q.flags;
endmodule

// file: verilog/ssu_regs.sv
// APB register bank: interrupt mask, write lock and violation status
`include "ssu_cfg.svh"
module ssu_regs
  import ssu_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            ce,
  input  wire ssu_apb_req_type apb_req,
  output ssu_apb_rsp_type      apb_rsp,
  input  wire ssu_src_type     ev_pulse,
  input  wire ssu_src_type     ev_level,
  output logic                 irq,
  output ssu_cfg_type          cfg,
  output logic                 lock_enable
);
  ssu_state_type q;
  ssu_state_type d;
  ssu_src_type   sticky;
  ssu_src_type   status;
  ssu_src_type   clr;
  logic          setup;
  logic          done;
  logic          wr_done;
  logic          rd_done;
  logic [2:0]    slot;

  // Protected register slot, or none
  function automatic logic [2:0] prot_slot(input logic [31:0] a);
    unique case (a)
      `SSU_A_CMR:  prot_slot = 3'h0;
      `SSU_A_RCMR: prot_slot = 3'h1;
      `SSU_A_RFMR: prot_slot = 3'h2;
      `SSU_A_TCMR: prot_slot = 3'h3;
      `SSU_A_TFMR: prot_slot = 3'h4;
      `SSU_A_RC0R: prot_slot = 3'h5;
      `SSU_A_RC1R: prot_slot = 3'h6;
      default:     prot_slot = `SSU_NO_SLOT;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [31:0] a);
    unique case (a)
      `SSU_A_STAT, `SSU_A_IER, `SSU_A_IDR, `SSU_A_IMR, `SSU_A_WPMR, `SSU_A_WPSR: is_mapped = 1'b1;
      default: is_mapped = prot_slot(a) != `SSU_NO_SLOT;
    endcase
  endfunction

  assign setup   = ce && apb_req.psel && !apb_req.penable && q.bus == SSU_IDLE;
  assign done    = ce && apb_req.psel && apb_req.penable && q.rsp.pready;
  assign wr_done = done && apb_req.pwrite;
  assign rd_done = done && !apb_req.pwrite;
  assign slot    = prot_slot(apb_req.paddr);

  // Only bits already returned are cleared, so events after the setup edge survive
  assign clr = (rd_done && apb_req.paddr == `SSU_A_STAT) ? (q.rsp.prdata[11:0] & `SSU_STICKY) : '0;

  ssu_flags u_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .set_in  (ev_pulse & `SSU_STICKY),
    .clr_in  (clr),
    .flags   (sticky)
  );

  // Ready and empty sources follow the datapath level
  assign status = (sticky & `SSU_STICKY) | (ev_level & ~`SSU_STICKY & `SSU_SRC_VALID);

  always_comb begin
    d = q;
    d.irq = |(status & q.mask);
    unique case (q.bus)
      SSU_IDLE: begin
        d.rsp.pready = 1'b0;
        if (setup) begin
          d.bus = SSU_ACC;
          d.rsp.pready = 1'b1;
          d.rsp.pslverr = !is_mapped(apb_req.paddr);
          d.rsp.prdata = '0;
          if (!apb_req.pwrite) begin
            unique case (apb_req.paddr)
              `SSU_A_STAT: d.rsp.prdata[11:0] = status;
              `SSU_A_IMR:  d.rsp.prdata[11:0] = q.mask;
              // Key field reads as zero
              `SSU_A_WPMR: d.rsp.prdata[`SSU_EN_BIT] = q.lock_en;
              `SSU_A_WPSR: begin
                d.rsp.prdata[`SSU_EN_BIT] = q.viol;
                d.rsp.prdata[`SSU_VSRC_HI:`SSU_VSRC_LO] = q.vsrc;
              end
              default: begin
                if (slot != `SSU_NO_SLOT) begin
                  d.rsp.prdata = q.cfg[slot];
                end
              end
            endcase
          end
        end
      end
      SSU_ACC: begin
        if (done) begin
          d.bus = SSU_IDLE;
          d.rsp.pready = 1'b0;
          d.rsp.pslverr = 1'b0;
        end
      end
    endcase
    if (rd_done && apb_req.paddr == `SSU_A_WPSR) begin
      d.viol = 1'b0;
      d.vsrc = `SSU_VSRC_RST;
    end
    if (wr_done) begin
      unique case (apb_req.paddr)
        `SSU_A_IER: d.mask = q.mask | (apb_req.pwdata[11:0] & `SSU_SRC_VALID);
        `SSU_A_IDR: d.mask = q.mask & ~apb_req.pwdata[11:0];
        `SSU_A_WPMR: begin
          // Wrong key discards the enable update
          if (apb_req.pwdata[`SSU_KEY_HI:`SSU_KEY_LO] == `SSU_LOCK_KEY) begin
            d.lock_en = apb_req.pwdata[`SSU_EN_BIT];
          end
        end
        default: begin
          if (slot != `SSU_NO_SLOT) begin
            if (q.lock_en) begin
              d.viol = 1'b1;
              d.vsrc = apb_req.paddr[15:0];
            end else begin
              d.cfg[slot] = apb_req.pwdata;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q.bus     <= SSU_IDLE;
      q.rsp     <= '0;
      q.irq     <= 1'b0;
      q.mask    <= `SSU_MASK_RST;
      q.lock_en <= 1'b0;
      q.viol    <= 1'b0;
      q.vsrc    <= `SSU_VSRC_RST;
      q.cfg     <= {7{`SSU_CFG_RST}};
    end else if (ce) begin
      q <= d;
    end
  end

  assign apb_rsp     = q.rsp;
  assign irq         = q.irq;
  assign cfg         = q.cfg;
  assign lock_enable = q.lock_en;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_wr(logic [31:0] a);
    wr_done && apb_req.paddr == a;
  endsequence

  sequence s_rd_setup(logic [31:0] a);
    setup && !apb_req.pwrite && apb_req.paddr == a;
  endsequence

  a_idr_clears_mask: assert property (
    s_wr(`SSU_A_IDR) |=> (q.mask & $past(apb_req.pwdata[11:0])) == '0)
    else $error("disable write left a mask bit set");

  a_ier_sets_mask: assert property (
    s_wr(`SSU_A_IER) |=> (q.mask & $past(apb_req.pwdata[11:0]) & `SSU_SRC_VALID)
                          == ($past(apb_req.pwdata[11:0]) & `SSU_SRC_VALID))
    else $error("enable write did not set mask bit");

  a_imr_read_value: assert property (
    s_rd_setup(`SSU_A_IMR) |=> apb_rsp.pready && apb_rsp.prdata == {20'h0, $past(q.mask)})
    else $error("mask view read wrong value");

  a_key_guard_hold: assert property (
    wr_done && apb_req.paddr == `SSU_A_WPMR && apb_req.pwdata[`SSU_KEY_HI:`SSU_KEY_LO] != `SSU_LOCK_KEY
    |=> $stable(lock_enable))
    else $error("lock enable changed with bad key");

  a_key_reads_zero: assert property (
    s_rd_setup(`SSU_A_WPMR) |=> apb_rsp.prdata[`SSU_KEY_HI:`SSU_KEY_LO] == '0)
    else $error("key field read nonzero");

  a_locked_cfg_stable: assert property (
    wr_done && q.lock_en && slot != `SSU_NO_SLOT |=> $stable(cfg))
    else $error("protected register written while locked");

  sequence s_blocked;
    wr_done && q.lock_en && slot != `SSU_NO_SLOT;
  endsequence

  a_violation_flagged: assert property (
    s_blocked ##1 (!rd_done || apb_req.paddr != `SSU_A_WPSR) [*2] |-> q.viol)
    else $error("violation flag not held");

  a_violation_source: assert property (
    s_blocked |=> q.vsrc == $past(apb_req.paddr[15:0]))
    else $error("violation source wrong");

  a_wpsr_read_clears: assert property (
    rd_done && apb_req.paddr == `SSU_A_WPSR |=> !q.viol && q.vsrc == '0)
    else $error("status read did not clear violation");

  a_stat_read_clears: assert property (
    rd_done && apb_req.paddr == `SSU_A_STAT && ev_pulse == '0
    |=> (sticky & $past(apb_rsp.prdata[11:0]) & `SSU_STICKY) == '0)
    else $error("sticky flag survived status read");

  a_irq_follows_flags: assert property (
    ce |=> irq == |($past(status) & $past(q.mask)))
    else $error("interrupt level wrong");

  // Bus handshake: one access cycle, no wait state
  a_ready_after_setup: assert property (
    setup |=> apb_rsp.pready)
    else $error("no ready after setup");

  a_ready_falls_after: assert property (
    done |=> !apb_rsp.pready && !apb_rsp.pslverr)
    else $error("ready stood past completion");

  a_unmapped_error: assert property (
    setup && !is_mapped(apb_req.paddr) |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
    else $error("unmapped access not refused");

  a_mapped_no_error: assert property (
    setup && is_mapped(apb_req.paddr) |=> !apb_rsp.pslverr)
    else $error("mapped access refused");

  a_disable_keeps_rest: assert property (
    s_wr(`SSU_A_IDR) |=> (q.mask & ~$past(apb_req.pwdata[11:0]))
                         == ($past(q.mask) & ~$past(apb_req.pwdata[11:0])))
    else $error("disable write changed an unselected bit");

  a_enable_keeps_rest: assert property (
    s_wr(`SSU_A_IER) |=> (q.mask & ~$past(apb_req.pwdata[11:0]))
                         == ($past(q.mask) & ~$past(apb_req.pwdata[11:0])))
    else $error("enable write changed an unselected bit");

  a_view_write_ignored: assert property (
    s_wr(`SSU_A_IMR) |=> $stable(q.mask))
    else $error("mask view write took effect");

  a_lock_read_value: assert property (
    s_rd_setup(`SSU_A_WPMR) |=> apb_rsp.prdata == {31'h0, $past(q.lock_en)})
    else $error("lock mode read wrong value");

  sequence s_keyed_lock;
    wr_done && apb_req.paddr == `SSU_A_WPMR && apb_req.pwdata[`SSU_KEY_HI:`SSU_KEY_LO] == `SSU_LOCK_KEY;
  endsequence

  a_key_good_update: assert property (
    s_keyed_lock |=> lock_enable == $past(apb_req.pwdata[`SSU_EN_BIT]))
    else $error("keyed write did not update lock enable");

  // A sequence cannot stand inside $past, so the keyed write is spelt out
  a_lock_needs_key: assert property (
    $changed(lock_enable) |-> $past(wr_done && apb_req.paddr == `SSU_A_WPMR
                                    && apb_req.pwdata[`SSU_KEY_HI:`SSU_KEY_LO] == `SSU_LOCK_KEY))
    else $error("lock enable changed without key");

  sequence s_open_wr;
    wr_done && !q.lock_en && slot != `SSU_NO_SLOT;
  endsequence

  a_open_cfg_write: assert property (
    s_open_wr |=> cfg[$past(slot)] == $past(apb_req.pwdata))
    else $error("unlocked write did not land");

  a_cfg_needs_write: assert property (
    $changed(cfg) |-> $past(wr_done && !q.lock_en && slot != `SSU_NO_SLOT))
    else $error("protected register changed without write");

  a_open_no_violation: assert property (
    s_open_wr |=> $stable(q.viol) && $stable(q.vsrc))
    else $error("unlocked write flagged a violation");

  a_viol_needs_block: assert property (
    $rose(q.viol) |-> $past(wr_done && q.lock_en && slot != `SSU_NO_SLOT))
    else $error("violation flag rose without blocked write");

  a_lock_status_write: assert property (
    s_wr(`SSU_A_WPSR) |=> $stable(q.viol) && $stable(q.vsrc))
    else $error("lock status write changed it");

  a_lock_status_value: assert property (
    s_rd_setup(`SSU_A_WPSR) |=> apb_rsp.prdata == {8'h00, $past(q.vsrc), 7'h00, $past(q.viol)})
    else $error("lock status read wrong value");

  a_stat_read_value: assert property (
    s_rd_setup(`SSU_A_STAT) |=> apb_rsp.prdata == {20'h00000, $past(status)})
    else $error("status read wrong value");

  a_event_sets_flag: assert property (
    ce && (ev_pulse & `SSU_STICKY) != '0
    |=> (sticky & $past(ev_pulse & `SSU_STICKY)) == $past(ev_pulse & `SSU_STICKY))
    else $error("event pulse did not set its flag");

  a_flag_holds: assert property (
    ce && !(rd_done && apb_req.paddr == `SSU_A_STAT) |=> (sticky & $past(sticky)) == $past(sticky))
    else $error("sticky flag dropped without status read");

  // Frozen enable must hold every flop, flags included
  a_ce_freeze_state: assert property (
    !ce |=> $stable(q) && $stable(sticky))
    else $error("state moved while enable low");
endmodule

// file: testbench/tb.sv
// Self-checking bench of the serial unit register bank over APB
`include "ssu_cfg.svh"
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb
  import ssu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk;
  logic            reset_n;
  logic            ce;
  ssu_apb_req_type apb_req;
  ssu_apb_rsp_type apb_rsp;
  ssu_src_type     ev_pulse;
  ssu_src_type     ev_level;
  logic            irq;
  ssu_cfg_type     cfg;
  logic            lock_enable;
  int              error_cnt;
  int              n_tests;
  logic [31:0]     rd;
  logic            err;
  logic [31:0]     prot [7];

  ssu_regs ssu_regs_i (
    .clk         (clk),
    .reset_n     (reset_n),
    .ce          (ce),
    .apb_req     (apb_req),
    .apb_rsp     (apb_rsp),
    .ev_pulse    (ev_pulse),
    .ev_level    (ev_level),
    .irq         (irq),
    .cfg         (cfg),
    .lock_enable (lock_enable)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded wait on pready, so a dead slave ends the run
  task automatic apb_xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (k == 20) begin
      error_cnt++;
      finish_test();
    end
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdr(input logic [31:0] a);
    apb_xfer(1'b0, a, 32'h00000000, rd, err);
  endtask

  // Pulse lands as a flag one edge later, irq one more
  task automatic pulse(input ssu_src_type s);
    @(posedge clk);
    ev_pulse <= s;
    @(posedge clk);
    ev_pulse <= '0;
    @(posedge clk);
    #1;
  endtask

  task automatic lvl(input ssu_src_type s, input logic x);
    @(posedge clk);
    ev_level <= s;
    repeat (3) @(posedge clk);
    #1;
    `CHK(irq, x);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    apb_req = '0;
    ev_pulse = '0;
    ev_level = '0;
    prot = '{`SSU_A_CMR, `SSU_A_RCMR, `SSU_A_RFMR, `SSU_A_TCMR, `SSU_A_TFMR, `SSU_A_RC0R, `SSU_A_RC1R};
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK(cfg, '0);
    rdr(`SSU_A_IMR);
    `CHK(rd, 32'h00000000);
    rdr(`SSU_A_WPMR);
    `CHK(rd, 32'h00000000);
    done("reset");
    wr(`SSU_A_IER, 32'h00000F33);
    rdr(`SSU_A_IMR);
    `CHK(rd, 32'h00000F33);
    wr(`SSU_A_IDR, 32'h00000021);
    wr(`SSU_A_IDR, 32'h00000000);
    wr(`SSU_A_IMR, 32'h00000000);
    rdr(`SSU_A_IMR);
    `CHK(rd, 32'h00000F12);
    done("mask");
    pulse(12'h020);
    `CHK(irq, 1'b0);
    rdr(`SSU_A_STAT);
    `CHK(rd & 32'h00000F33, 32'h00000020);
    pulse(12'h100);
    `CHK(irq, 1'b1);
    rdr(`SSU_A_STAT);
    `CHK(rd & 32'h00000F33, 32'h00000100);
    rdr(`SSU_A_STAT);
    `CHK(rd & 32'h00000F33, 32'h00000000);
    `CHK(irq, 1'b0);
    lvl(12'h001, 1'b0);
    lvl(12'h010, 1'b1);
    lvl(12'h000, 1'b0);
    done("events");
    // Enable low freezes flags and interrupt, so the pulse is lost
    @(posedge clk);
    ce <= 1'b0;
    pulse(12'h200);
    `CHK(irq, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rdr(`SSU_A_STAT);
    `CHK(rd & 32'h00000F33, 32'h00000000);
    done("enable");
    wr(`SSU_A_WPMR, 32'h12345601);
    `CHK(lock_enable, 1'b0);
    wr(`SSU_A_WPMR, {`SSU_LOCK_KEY, 8'h01});
    rdr(`SSU_A_WPMR);
    `CHK(rd, 32'h00000001);
    wr(`SSU_A_WPMR, {24'h535342, 8'h00});
    `CHK(lock_enable, 1'b1);
    for (int i = 0; i < 7; i++) begin
      wr(prot[i], 32'hA5A50000 + 32'(i));
      `CHK(cfg[i], 32'h00000000);
      rdr(`SSU_A_IMR);
      rdr(`SSU_A_WPSR);
      `CHK(rd, {8'h00, prot[i][15:0], 8'h01});
      rdr(`SSU_A_WPSR);
      `CHK(rd, 32'h00000000);
    end
    done("locked");
    wr(`SSU_A_WPMR, {`SSU_LOCK_KEY, 8'h00});
    `CHK(lock_enable, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wr(prot[i], 32'hC0DE0000 + 32'(i));
      `CHK(cfg[i], 32'hC0DE0000 + 32'(i));
    end
    rdr(`SSU_A_WPSR);
    `CHK(rd, 32'h00000000);
    done("unlocked");
    // Unmapped place answers with an error and zero data
    rdr(32'hF0010100);
    `CHK(err, 1'b1);
    `CHK(rd, 32'h00000000);
    done("refused");
    finish_test();
  end
endmodule
